// [logic/omi_flash_gen.sv]
// Purpose: slow and fast square waves for the stop indicator
// Assumes: half periods fit the counter width
// Notes: 4:1 rate ratio keeps the patterns easy to tell apart
`include "omi_defines.svh"
`default_nettype none
module omi_flash_gen #(
  parameter int SLOW_HALF_CYC = `OMI_SLOW_HALF_CYC,
  parameter int FAST_HALF_CYC = `OMI_FAST_HALF_CYC
)
(
  input wire logic mclk,
  input wire logic resetn,
  omi_flash_if.gen flash
);
  localparam logic [`OMI_FLASH_CNT_W-1:0] SLOW_LAST = `OMI_FLASH_CNT_W'(SLOW_HALF_CYC - 1);
  localparam logic [`OMI_FLASH_CNT_W-1:0] FAST_LAST = `OMI_FLASH_CNT_W'(FAST_HALF_CYC - 1);
  logic [`OMI_FLASH_CNT_W-1:0] slow_cnt_r, slow_cnt_nxt, fast_cnt_r, fast_cnt_nxt;
  logic slow_r, slow_nxt, fast_r, fast_nxt;

  always_comb
  begin
    slow_cnt_nxt = slow_cnt_r + `OMI_FLASH_CNT_W'(1);
    slow_nxt = slow_r;
    fast_cnt_nxt = fast_cnt_r + `OMI_FLASH_CNT_W'(1);
    fast_nxt = fast_r;
    if (slow_cnt_r == SLOW_LAST)
    begin
      slow_cnt_nxt = '0;
      slow_nxt = !slow_r;
    end
    if (fast_cnt_r == FAST_LAST)
    begin
      fast_cnt_nxt = '0;
      fast_nxt = !fast_r;
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      slow_cnt_r <= '0;
      fast_cnt_r <= '0;
      slow_r <= 1'b0;
      fast_r <= 1'b0;
    end
    else
    begin
      slow_cnt_r <= slow_cnt_nxt;
      fast_cnt_r <= fast_cnt_nxt;
      slow_r <= slow_nxt;
      fast_r <= fast_nxt;
    end
  end

  assign flash.slow_phase = slow_r;
  assign flash.fast_phase = fast_r;

  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);

  slow_toggle_rate_a: assert property ($changed(slow_r) |-> $past(slow_cnt_r) == SLOW_LAST)
    else $error("slow flash toggled off its half period");
  fast_toggle_rate_a: assert property ($changed(fast_r) |-> $past(fast_cnt_r) == FAST_LAST)
    else $error("fast flash toggled off its half period");
endmodule
`default_nettype wire

// [logic/omi_mode_indicator.sv]
// Purpose: operating-mode tracker, front-panel indicators and output-disable command
// Assumes: Avalon-MM slave on mclk; panel and fault pins are asynchronous
// Notes: one answer per request, waitrequest low for exactly one cycle
// Notes on behaviour
// - the block is always in exactly one of start-up, run, soft stop or hard stop.
// - in start-up or while a program test runs, run, stop and fault lamps stay dark.
// - in run the run lamp is lit steadily and the stop and fault lamps are dark.
// - power-up at stop without init error, a multiprocessor halt or a stop command give soft stop, steady lamp.
// - an unhandled run error, a program stop statement or the end of a program test give soft stop, slow flash.
// - an overall reset gives soft stop with the stop lamp flashing fast.
// - hard stop lights only the fault lamp and runs no program.
// - hard stop is left only by a power cycle.
// - hard-stop instruction, OS memory timeout or parity error, interrupt stack overflow or serious error force hard stop.
// - in start-up and run an event calls organization block 1 to 35.
// - the output-disable command is off in run and on in stop and start-up.
`include "omi_defines.svh"
`default_nettype none
module omi_mode_indicator #(
  parameter int SLOW_HALF_CYC = `OMI_SLOW_HALF_CYC,
  parameter int FAST_HALF_CYC = `OMI_FAST_HALF_CYC
)
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [`OMI_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic selector_stop,
  input wire logic multiprocessor_halt,
  input wire logic init_error,
  input wire logic os_mem_timeout,
  input wire logic os_mem_parity,
  input wire logic interrupt_stack_overflow,
  input wire logic serious_system_error,
  output logic run_indicator,
  output logic stop_indicator,
  output logic system_fault_indicator,
  output logic output_disable_command,
  output logic organization_block_call,
  output logic [`OMI_OB_W-1:0] organization_block_number,
  output logic irq
);

  function automatic logic is_active(input omi_pkg::omi_mode_type m);
    is_active = (m == omi_pkg::mode_startup) || (m == omi_pkg::mode_run);
  endfunction

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [6:0] sync1_r, sync2_r;
  logic sel_stop_s, mp_halt_s, init_err_s;
  logic [3:0] hard_pins;

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      sync1_r <= 7'h00;
      sync2_r <= 7'h00;
    end
    else
    begin
      sync1_r <= {selector_stop, multiprocessor_halt, init_error, os_mem_timeout, os_mem_parity,
                  interrupt_stack_overflow, serious_system_error};
      sync2_r <= sync1_r;
    end
  end

  assign sel_stop_s = sync2_r[6];
  assign mp_halt_s = sync2_r[5];
  assign init_err_s = sync2_r[4];
  assign hard_pins = sync2_r[3:0];

  // ****************************************
  // bus slave
  // ****************************************
  logic wait_r, wait_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic acc_wr, acc_rd;
  logic [31:0] cmd;
  omi_pkg::omi_mode_type mode_r, mode_nxt;
  omi_pkg::omi_pattern_type pat_r, pat_nxt;
  logic [`OMI_CAUSE_W-1:0] cause_r, cause_nxt, hard_cause;
  logic [1:0] settle_r, settle_nxt;
  logic pwr_done_r, pwr_done_nxt, test_r, test_nxt;
  logic [`OMI_IRQ_W-1:0] stat_r, stat_nxt, mask_r, mask_nxt, ev, clr;
  logic ob_wr, ob_ok;

  // request is answered one cycle after it is seen
  assign acc_wr = avs_write && !wait_r;
  assign acc_rd = avs_read && !wait_r;
  assign cmd = (acc_wr && avs_address == `OMI_REG_CTRL) ? avs_writedata : 32'h0000_0000;

  always_comb
  begin
    wait_nxt = !((avs_read || avs_write) && wait_r);
    rdata_nxt = rdata_r;
    if (avs_read && wait_r)
    begin
      rdata_nxt = 32'h0000_0000;
      case (avs_address)
        `OMI_REG_CTRL: rdata_nxt[`OMI_CTRL_TEST_ACTIVE] = test_r;
        `OMI_REG_STATUS:
        begin
          rdata_nxt[`OMI_STAT_MODE_LSB +: 2] = mode_r;
          rdata_nxt[`OMI_STAT_PAT_LSB +: 2] = pat_r;
          rdata_nxt[`OMI_STAT_CAUSE_LSB +: `OMI_CAUSE_W] = cause_r;
          rdata_nxt[`OMI_STAT_ODC] = output_disable_command;
          rdata_nxt[`OMI_STAT_TEST] = test_r;
        end
        `OMI_REG_OBCALL: rdata_nxt[`OMI_OB_W-1:0] = organization_block_number;
        `OMI_REG_IRQ_STAT: rdata_nxt[`OMI_IRQ_W-1:0] = stat_r;
        `OMI_REG_IRQ_MASK: rdata_nxt[`OMI_IRQ_W-1:0] = mask_r;
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      wait_r <= 1'b1;
      rdata_r <= 32'h0000_0000;
    end
    else
    begin
      wait_r <= wait_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign avs_waitrequest = wait_r;
  assign avs_readdata = rdata_r;

  // ****************************************
  // operating mode
  // ****************************************
  assign hard_cause = {hard_pins, cmd[`OMI_CTRL_HALT_INSTR]};

  always_comb
  begin
    mode_nxt = mode_r;
    pat_nxt = pat_r;
    cause_nxt = cause_r;
    settle_nxt = settle_r;
    pwr_done_nxt = pwr_done_r;
    test_nxt = test_r;
    if (acc_wr && avs_address == `OMI_REG_CTRL)
    begin
      test_nxt = avs_writedata[`OMI_CTRL_TEST_ACTIVE] && !avs_writedata[`OMI_CTRL_TEST_END];
    end
    if (!pwr_done_r)
    begin
      settle_nxt = settle_r + 2'h1;
    end
    if (mode_r != omi_pkg::mode_hard_stop)
    begin
      if (|hard_cause)
      begin
        mode_nxt = omi_pkg::mode_hard_stop;
        cause_nxt = hard_cause;
        test_nxt = 1'b0;
      end
      else if (cmd[`OMI_CTRL_OVR_RESET])
      begin
        mode_nxt = omi_pkg::mode_soft_stop;
        pat_nxt = omi_pkg::pat_fast;
      end
      // power-up selector check, once the pins have settled
      else if (!pwr_done_r && settle_r == `OMI_SETTLE_CYC)
      begin
        pwr_done_nxt = 1'b1;
        if (init_err_s || sel_stop_s)
        begin
          mode_nxt = omi_pkg::mode_soft_stop;
          pat_nxt = init_err_s ? omi_pkg::pat_slow : omi_pkg::pat_steady;
        end
      end
      // error, stop statement, end of test
      else if (cmd[`OMI_CTRL_TEST_END] || (is_active(mode_r) &&
               (cmd[`OMI_CTRL_PROG_STOP] || (mode_r == omi_pkg::mode_run && cmd[`OMI_CTRL_RUN_ERR]))))
      begin
        mode_nxt = omi_pkg::mode_soft_stop;
        pat_nxt = omi_pkg::pat_slow;
      end
      // stop command, selector or multiprocessor halt
      else if (is_active(mode_r) && pwr_done_r && (cmd[`OMI_CTRL_STOP] || sel_stop_s || mp_halt_s))
      begin
        mode_nxt = omi_pkg::mode_soft_stop;
        pat_nxt = omi_pkg::pat_steady;
      end
      else
      begin
        unique case (mode_r)
          omi_pkg::mode_startup:
          begin
            if (pwr_done_r && cmd[`OMI_CTRL_STARTUP_DONE])
            begin
              mode_nxt = omi_pkg::mode_run;
            end
          end
          omi_pkg::mode_soft_stop:
          begin
            // start-up stays possible from any soft stop
            if (cmd[`OMI_CTRL_START] && !sel_stop_s && !mp_halt_s)
            begin
              mode_nxt = omi_pkg::mode_startup;
            end
          end
          omi_pkg::mode_run: mode_nxt = mode_r;
          omi_pkg::mode_hard_stop: mode_nxt = mode_r;
        endcase
      end
    end
    else
    begin
      test_nxt = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      mode_r <= omi_pkg::mode_startup;
      pat_r <= omi_pkg::pat_steady;
      cause_r <= 5'h00;
      settle_r <= 2'h0;
      pwr_done_r <= 1'b0;
      test_r <= 1'b0;
    end
    else
    begin
      mode_r <= mode_nxt;
      pat_r <= pat_nxt;
      cause_r <= cause_nxt;
      settle_r <= settle_nxt;
      pwr_done_r <= pwr_done_nxt;
      test_r <= test_nxt;
    end
  end

  // ****************************************
  // indicators and organization block calls
  // ****************************************
  omi_flash_if flash_bus();

  omi_flash_gen #(
    .SLOW_HALF_CYC(SLOW_HALF_CYC),
    .FAST_HALF_CYC(FAST_HALF_CYC)
  )
  u_flash (
    .mclk(mclk),
    .resetn(resetn),
    .flash(flash_bus)
  );

  logic run_nxt, stop_nxt, fault_nxt, odc_nxt, ob_call_nxt;
  logic [`OMI_OB_W-1:0] ob_num_nxt;

  assign ob_wr = acc_wr && avs_address == `OMI_REG_OBCALL;
  assign ob_ok = is_active(mode_r) && avs_writedata[`OMI_OB_W-1:0] >= `OMI_OB_MIN
                 && avs_writedata[`OMI_OB_W-1:0] <= `OMI_OB_MAX;

  always_comb
  begin
    // start-up and program test stay dark
    run_nxt = mode_r == omi_pkg::mode_run && !test_r;
    stop_nxt = 1'b0;
    if (mode_r == omi_pkg::mode_soft_stop && !test_r)
    begin
      unique case (pat_r)
        omi_pkg::pat_steady: stop_nxt = 1'b1;
        omi_pkg::pat_slow: stop_nxt = flash_bus.slow_phase;
        omi_pkg::pat_fast: stop_nxt = flash_bus.fast_phase;
        default: stop_nxt = 1'b1;
      endcase
    end
    // fault lamp alone in hard stop
    fault_nxt = mode_r == omi_pkg::mode_hard_stop;
    odc_nxt = mode_r != omi_pkg::mode_run;
    // call only from start-up or run
    ob_call_nxt = ob_wr && ob_ok;
    ob_num_nxt = ob_call_nxt ? avs_writedata[`OMI_OB_W-1:0] : organization_block_number;
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      run_indicator <= 1'b0;
      stop_indicator <= 1'b0;
      system_fault_indicator <= 1'b0;
      output_disable_command <= 1'b1;
      organization_block_call <= 1'b0;
      organization_block_number <= 6'h00;
    end
    else
    begin
      run_indicator <= run_nxt;
      stop_indicator <= stop_nxt;
      system_fault_indicator <= fault_nxt;
      output_disable_command <= odc_nxt;
      organization_block_call <= ob_call_nxt;
      organization_block_number <= ob_num_nxt;
    end
  end

  // ****************************************
  // interrupt status and mask
  // ****************************************
  logic irq_nxt;

  always_comb
  begin
    ev = 3'h0;
    ev[`OMI_IRQ_MODE] = mode_nxt != mode_r;
    ev[`OMI_IRQ_HARD] = mode_nxt == omi_pkg::mode_hard_stop && mode_r != omi_pkg::mode_hard_stop;
    ev[`OMI_IRQ_OBREJ] = ob_wr && !ob_ok;
    // only bits already returned are cleared, so a fresh event survives the read
    clr = (acc_rd && avs_address == `OMI_REG_IRQ_STAT) ? rdata_r[`OMI_IRQ_W-1:0] : 3'h0;
    stat_nxt = (stat_r & ~clr) | ev;
    mask_nxt = (acc_wr && avs_address == `OMI_REG_IRQ_MASK) ? avs_writedata[`OMI_IRQ_W-1:0] : mask_r;
    irq_nxt = |(stat_nxt & mask_nxt);
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      stat_r <= 3'h0;
      mask_r <= `OMI_IRQ_MASK_RST;
      irq <= 1'b0;
    end
    else
    begin
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      irq <= irq_nxt;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);

  sequence clean_s;
    !(|hard_pins) && mode_r == omi_pkg::mode_run;
  endsequence
  sequence stop_cmd_s;
    clean_s and (cmd == 32'h0000_0004);
  endsequence
  sequence soft_steady_s;
    mode_r == omi_pkg::mode_soft_stop && pat_r == omi_pkg::pat_steady;
  endsequence

  mode_legal_a: assert property (mode_r inside {omi_pkg::mode_startup, omi_pkg::mode_run,
    omi_pkg::mode_soft_stop, omi_pkg::mode_hard_stop}) else $error("mode out of range");
  dark_lamps_a: assert property ((mode_r == omi_pkg::mode_startup ||
    (test_r && mode_r != omi_pkg::mode_hard_stop)) |=> !run_indicator && !stop_indicator && !system_fault_indicator)
    else $error("lamp lit in start-up or test");
  run_lamp_a: assert property (mode_r == omi_pkg::mode_run && !test_r |=>
    run_indicator && !stop_indicator && !system_fault_indicator) else $error("run lamps wrong");
  stop_steady_a: assert property (stop_cmd_s |=> soft_steady_s ##1 stop_indicator)
    else $error("stop command did not give steady stop");
  slow_stop_a: assert property (clean_s and (cmd == 32'h0000_0008) |=>
    mode_r == omi_pkg::mode_soft_stop && pat_r == omi_pkg::pat_slow) else $error("stop statement missed");
  overall_reset_a: assert property (cmd[`OMI_CTRL_OVR_RESET] && !(|hard_cause) &&
    mode_r != omi_pkg::mode_hard_stop |=> mode_r == omi_pkg::mode_soft_stop && pat_r == omi_pkg::pat_fast)
    else $error("overall reset did not flash fast");
  hard_lamp_a: assert property (mode_r == omi_pkg::mode_hard_stop |=>
    system_fault_indicator && !run_indicator && !stop_indicator && !organization_block_call)
    else $error("hard stop lamps wrong");
  hard_hold_a: assert property (mode_r == omi_pkg::mode_hard_stop |=> mode_r == omi_pkg::mode_hard_stop)
    else $error("hard stop left");
  hard_entry_a: assert property (|hard_cause |=> mode_r == omi_pkg::mode_hard_stop && cause_r != 5'h00)
    else $error("hard stop cause ignored");
  ob_call_a: assert property (ob_wr && ob_ok |=> organization_block_call &&
    organization_block_number == $past(avs_writedata[`OMI_OB_W-1:0])) else $error("block call lost");
  odc_follow_a: assert property (mode_r == omi_pkg::mode_run |=> !output_disable_command)
    else $error("outputs blocked in run");
endmodule
`default_nettype wire

// [pkg/omi_defines.svh]
// Purpose: offsets, field positions, reset values and timing counts of the mode indicator
// Assumes: 50 MHz mclk
// Notes: definitions only
`ifndef OMI_DEFINES_SVH
`define OMI_DEFINES_SVH

// ****************************************
// register map (byte addresses)
// ****************************************
`define OMI_ADDR_W 5
`define OMI_REG_CTRL 5'h00
`define OMI_REG_STATUS 5'h04
`define OMI_REG_OBCALL 5'h08
`define OMI_REG_IRQ_STAT 5'h0C
`define OMI_REG_IRQ_MASK 5'h10

// ****************************************
// control word bits
// ****************************************
`define OMI_CTRL_START 0
`define OMI_CTRL_STARTUP_DONE 1
`define OMI_CTRL_STOP 2
`define OMI_CTRL_PROG_STOP 3
`define OMI_CTRL_RUN_ERR 4
`define OMI_CTRL_OVR_RESET 5
`define OMI_CTRL_HALT_INSTR 6
`define OMI_CTRL_TEST_ACTIVE 7
`define OMI_CTRL_TEST_END 8

// ****************************************
// status word fields
// ****************************************
`define OMI_STAT_MODE_LSB 0
`define OMI_STAT_PAT_LSB 2
`define OMI_STAT_CAUSE_LSB 4
`define OMI_STAT_ODC 9
`define OMI_STAT_TEST 10
`define OMI_CAUSE_W 5

// ****************************************
// interrupt bits and reset values
// ****************************************
`define OMI_IRQ_W 3
`define OMI_IRQ_MODE 0
`define OMI_IRQ_HARD 1
`define OMI_IRQ_OBREJ 2
`define OMI_IRQ_MASK_RST 3'h0
`define OMI_OB_W 6
`define OMI_OB_MIN 6'h01
`define OMI_OB_MAX 6'h23

// ****************************************
// timing
// ****************************************
`define OMI_CLK_MHZ 50
`define OMI_SLOW_HALF_US 250000
`define OMI_FAST_HALF_US 62500
`define OMI_SLOW_HALF_CYC (`OMI_SLOW_HALF_US * `OMI_CLK_MHZ)
`define OMI_FAST_HALF_CYC (`OMI_FAST_HALF_US * `OMI_CLK_MHZ)
`define OMI_FLASH_CNT_W 24
`define OMI_SETTLE_CYC 2'h3

`endif

// [pkg/omi_flash_if.sv]
// Purpose: flash phases from the divider to the mode logic
// Assumes: single mclk domain
// Notes: none
`default_nettype none
interface omi_flash_if;
  logic slow_phase;
  logic fast_phase;
  modport gen (output slow_phase, output fast_phase);
  modport sink (input slow_phase, input fast_phase);
endinterface
`default_nettype wire

// [pkg/omi_pkg.sv]
// Purpose: types of the mode indicator
// Assumes: nothing
// Notes: constants live in omi_defines.svh
`default_nettype none
package omi_pkg;
  typedef enum logic [1:0] {mode_startup, mode_run, mode_soft_stop, mode_hard_stop} omi_mode_type;
  typedef enum logic [1:0] {pat_steady, pat_slow, pat_fast} omi_pattern_type;
endpackage
`default_nettype wire

// [testbench/testbench.sv]
// Purpose: self-checking bench of the mode indicator through its bus and panel pins
// Assumes: shortened flash half periods, one bus answer per request
// Notes: each hard-stop cause gets its own power cycle, the only way out
`include "omi_defines.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SLOW = 16;
  localparam int FAST = 4;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic [`OMI_ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic selector_stop = 1'b1;
  logic multiprocessor_halt = 1'b0;
  logic init_error = 1'b0;
  logic [3:0] fault_pins = 4'h0;
  logic run_indicator;
  logic stop_indicator;
  logic system_fault_indicator;
  logic output_disable_command;
  logic organization_block_call;
  logic [`OMI_OB_W-1:0] organization_block_number;
  logic irq;
  int mismatches = 0;
  int total_checks = 0;
  int ob_pulses = 0;
  logic [31:0] q;
  int n0;
  int bits [4] = '{`OMI_CTRL_STOP, `OMI_CTRL_PROG_STOP, `OMI_CTRL_RUN_ERR, `OMI_CTRL_OVR_RESET};
  logic [1:0] pats [4] = '{2'h0, 2'h1, 2'h1, 2'h2};

  omi_mode_indicator #(.SLOW_HALF_CYC(SLOW), .FAST_HALF_CYC(FAST)) i_dut (
    .mclk(mclk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .selector_stop(selector_stop),
    .multiprocessor_halt(multiprocessor_halt), .init_error(init_error),
    .os_mem_timeout(fault_pins[3]), .os_mem_parity(fault_pins[2]),
    .interrupt_stack_overflow(fault_pins[1]), .serious_system_error(fault_pins[0]),
    .run_indicator(run_indicator), .stop_indicator(stop_indicator),
    .system_fault_indicator(system_fault_indicator), .output_disable_command(output_disable_command),
    .organization_block_call(organization_block_call),
    .organization_block_number(organization_block_number), .irq(irq));

  always #10 mclk = ~mclk;

  always @(posedge mclk)
    if (organization_block_call === 1'b1)
      ob_pulses <= ob_pulses + 1;

  // ****************************************
  // bus and compare tasks
  // ****************************************
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [`OMI_ADDR_W-1:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    n = 0;
    @(posedge mclk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= d;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    r = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 50)
    begin
      mismatches++;
      $display("[FAIL] %0t bus answer missing", $time);
    end
  endtask

  task automatic wr_reg(input logic [`OMI_ADDR_W-1:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t word %h expected %h", $time, got, exp);
    end
  endtask

  // order: run, stop, fault
  task automatic check_lamps(input logic [2:0] exp);
    total_checks++;
    if ({run_indicator, stop_indicator, system_fault_indicator} !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t lamps differ from %b", $time, exp);
    end
  endtask

  // a square wave must be inverted after one half period and back after two
  task automatic check_flash(input int half);
    logic s0;
    s0 = stop_indicator;
    wait_cyc(half);
    check_word({31'h0, stop_indicator}, {31'h0, ~s0});
    wait_cyc(half);
    check_word({31'h0, stop_indicator}, {31'h0, s0});
  endtask

  function automatic logic [31:0] st(input logic [1:0] m, input logic [1:0] p, input logic o);
    st = 32'h0;
    st[1:0] = m;
    st[3:2] = p;
    st[`OMI_STAT_ODC] = o;
  endfunction

  task automatic do_reset();
    @(posedge mclk);
    resetn <= 1'b0;
    selector_stop <= 1'b1;
    fault_pins <= 4'h0;
    wait_cyc(8);
    resetn <= 1'b1;
    wait_cyc(6);
  endtask

  task automatic go_run();
    @(posedge mclk);
    selector_stop <= 1'b0;
    wait_cyc(3);
    wr_reg(`OMI_REG_CTRL, 32'h1 << `OMI_CTRL_START);
    wr_reg(`OMI_REG_CTRL, 32'h1 << `OMI_CTRL_STARTUP_DONE);
    wait_cyc(3);
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    wait_cyc(20000);
    mismatches++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_sim();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    do_reset();
    bus(1'b0, `OMI_REG_STATUS, 32'h0, q);
    check_word(q & 32'h0000_020F, st(omi_pkg::mode_soft_stop, omi_pkg::pat_steady, 1'b1));
    check_lamps(3'b010);
    bus(1'b0, `OMI_REG_IRQ_MASK, 32'h0, q);
    check_word(q, 32'h0);
    bus(1'b0, 5'h1C, 32'h0, q);
    check_word(q, 32'h0);
    wr_reg(`OMI_REG_IRQ_MASK, 32'h7);
    bus(1'b0, `OMI_REG_IRQ_MASK, 32'h0, q);
    check_word(q, 32'h7);
    wait_cyc(2);
    check_word({31'h0, irq}, 32'h1);
    bus(1'b0, `OMI_REG_IRQ_STAT, 32'h0, q);
    check_word({31'h0, q[`OMI_IRQ_MODE]}, 32'h1);
    wait_cyc(2);
    check_word({31'h0, irq}, 32'h0);
    // start-up: all dark, outputs blocked, block calls allowed
    @(posedge mclk);
    selector_stop <= 1'b0;
    wait_cyc(3);
    wr_reg(`OMI_REG_CTRL, 32'h1 << `OMI_CTRL_START);
    wait_cyc(3);
    bus(1'b0, `OMI_REG_STATUS, 32'h0, q);
    check_word(q & 32'h0000_0203, st(omi_pkg::mode_startup, 2'h0, 1'b1));
    check_lamps(3'b000);
    check_word({31'h0, output_disable_command}, 32'h1);
    n0 = ob_pulses;
    wr_reg(`OMI_REG_OBCALL, 32'h5);
    wait_cyc(3);
    check_word(ob_pulses - n0, 32'h1);
    check_word({26'h0, organization_block_number}, 32'h5);
    wr_reg(`OMI_REG_OBCALL, 32'h24);
    wait_cyc(3);
    check_word(ob_pulses - n0, 32'h1);
    bus(1'b0, `OMI_REG_IRQ_STAT, 32'h0, q);
    check_word({31'h0, q[`OMI_IRQ_OBREJ]}, 32'h1);
    wr_reg(`OMI_REG_CTRL, 32'h1 << `OMI_CTRL_STARTUP_DONE);
    wait_cyc(3);
    bus(1'b0, `OMI_REG_STATUS, 32'h0, q);
    check_word(q & 32'h0000_020F, st(omi_pkg::mode_run, omi_pkg::pat_steady, 1'b0));
    check_lamps(3'b100);
    check_word({31'h0, output_disable_command}, 32'h0);
    wr_reg(`OMI_REG_OBCALL, 32'h23);
    wr_reg(`OMI_REG_OBCALL, 32'h0);
    wait_cyc(3);
    check_word(ob_pulses - n0, 32'h2);
    check_word({26'h0, organization_block_number}, 32'h23);
    // program test darkens the panel; its end gives slow flash
    wr_reg(`OMI_REG_CTRL, 32'h1 << `OMI_CTRL_TEST_ACTIVE);
    wait_cyc(3);
    check_lamps(3'b000);
    bus(1'b0, `OMI_REG_CTRL, 32'h0, q);
    check_word(q, 32'h80);
    wr_reg(`OMI_REG_CTRL, 32'h1 << `OMI_CTRL_TEST_END);
    wait_cyc(3);
    bus(1'b0, `OMI_REG_STATUS, 32'h0, q);
    check_word(q & 32'h0000_060F, st(omi_pkg::mode_soft_stop, omi_pkg::pat_slow, 1'b1));
    check_flash(SLOW);
    for (int k = 0; k < 4; k++)
    begin
      go_run();
      wr_reg(`OMI_REG_CTRL, 32'h1 << bits[k]);
      wait_cyc(3);
      bus(1'b0, `OMI_REG_STATUS, 32'h0, q);
      check_word(q & 32'h0000_020F, st(omi_pkg::mode_soft_stop, pats[k], 1'b1));
      if (pats[k] == 2'h0)
        check_lamps(3'b010);
      else
        check_flash(pats[k] == 2'h1 ? SLOW : FAST);
    end
    go_run();
    multiprocessor_halt <= 1'b1;
    wait_cyc(6);
    check_lamps(3'b010);
    multiprocessor_halt <= 1'b0;
    // init error at power-up gives slow flash instead of steady stop
    init_error <= 1'b1;
    do_reset();
    bus(1'b0, `OMI_REG_STATUS, 32'h0, q);
    check_word(q & 32'h0000_020F, st(omi_pkg::mode_soft_stop, omi_pkg::pat_slow, 1'b1));
    init_error <= 1'b0;
    // hard stop: every cause, then nothing but power releases it
    for (int i = 0; i < 5; i++)
    begin
      do_reset();
      go_run();
      if (i == 0)
        wr_reg(`OMI_REG_CTRL, 32'h1 << `OMI_CTRL_HALT_INSTR);
      else
        fault_pins <= 4'h1 << (i - 1);
      wait_cyc(6);
      bus(1'b0, `OMI_REG_STATUS, 32'h0, q);
      check_word(q & 32'h0000_03F3, st(omi_pkg::mode_hard_stop, 2'h0, 1'b1) | (32'h10 << i));
      check_lamps(3'b001);
      bus(1'b0, `OMI_REG_IRQ_STAT, 32'h0, q);
      check_word({31'h0, q[`OMI_IRQ_HARD]}, 32'h1);
      fault_pins <= 4'h0;
      n0 = ob_pulses;
      wr_reg(`OMI_REG_OBCALL, 32'h1);
      wr_reg(`OMI_REG_CTRL, 32'h1 << `OMI_CTRL_OVR_RESET);
      go_run();
      bus(1'b0, `OMI_REG_STATUS, 32'h0, q);
      check_word(q & 32'h0000_0003, 32'h3);
      check_word(ob_pulses - n0, 32'h0);
      check_lamps(3'b001);
    end
    end_sim();
  end
endmodule
`default_nettype wire
